// ==== src/secl_pkg.sv ====
package secl_pkg;
    // Bus headers, upper seven bits of the first byte
    localparam logic [6:0] ARR_HDR = 7'h51;
    localparam logic [6:0] IDS_HDR = 7'h59;
    localparam int MEM_BYTES = 32768;
    localparam int AW = 15;
    localparam int PAGE_BYTES = 64;
    localparam int PW = 9;
    localparam logic [7:0] ERASED = 8'hff;
    localparam logic [7:0] CFG_RESET = 8'h3d;
    localparam int LOCK_POS = 1;
    // Field positions inside the first address byte of the identifier space
    localparam int SPACE_POS = 1;
    localparam int CFGSEL_POS = 2;
    localparam int CLK_NS = 5;
    localparam int TWR_NS = 5000000;
    localparam int TWR_CYC = TWR_NS / CLK_NS;
    localparam int TW = 20;
    // Quarter of a generated serial clock period, least time
    localparam int QTR_NS = 40;
    localparam int QTR_CYC = (QTR_NS + CLK_NS - 1) / CLK_NS;
    localparam int DW = 4;
    typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} secl_op_e;
endpackage

// ==== src/secl_if.sv ====
`timescale 1ns/10ps
interface secl_if;
    logic scl;
    logic m_sda_o;
    logic m_sda_oe;
    logic s_sda_o;
    logic s_sda_oe;
    logic sda;
    // Open-drain wire with pull-up: low while any enabled driver outputs zero
    assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));
    modport master (output scl, output m_sda_o, output m_sda_oe, input sda);
    modport slave (input scl, input sda, output s_sda_o, output s_sda_oe);
endinterface

// ==== src/secl_sync.sv ====
`timescale 1ns/10ps
module secl_sync #(parameter int W = 2) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_ff, s2_ff, nxt_s1, nxt_s2;
    always_comb begin
        nxt_s1 = d_i;
        nxt_s2 = s1_ff;
    end
    // Idle bus level is high, so reset to ones to avoid a false edge
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            s1_ff <= '1;
            s2_ff <= '1;
        end else begin
            s1_ff <= nxt_s1;
            s2_ff <= nxt_s2;
        end
    end
    assign q_o = s2_ff;
endmodule // secl_sync

// ==== src/secl_dev.sv ====
`timescale 1ns/10ps
module secl_dev import secl_pkg::*; #(
    parameter int TWR = TWR_CYC,
    parameter logic [127:0] FACTORY_ID = 128'h5a01_0203_0405_0607_0809_0a0b_0c0d_0e0f // Arbitrary value
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    secl_if.slave bus,
    output logic busy_o,
    output logic lock_o
);
    typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_MACK} secl_st_e;
    typedef enum logic [1:0] {B_HDR, B_AHI, B_ALO, B_DATA} secl_role_e;

    function automatic logic [7:0] fid_byte(input logic [3:0] i);
        fid_byte = 8'(FACTORY_ID >> {~i, 3'b000});
    endfunction

    logic scl_s, sda_s, rise, fall, start, stop;
    secl_st_e st_ff, nxt_st;
    secl_role_e role_ff, nxt_role;
    logic [3:0] bc_ff, nxt_bc, uidx_ff, nxt_uidx;
    logic [7:0] sh_ff, nxt_sh, ahi_ff, nxt_ahi, mem_q_ff, txb, cfg_rd, b;
    logic scl_d_ff, nxt_scl_d, sda_d_ff, nxt_sda_d, oe_ff, nxt_oe, ackd_ff, nxt_ackd;
    logic rw_ff, nxt_rw, ids_ff, nxt_ids, space_sel_ff, nxt_space_sel, a10_ff, nxt_a10;
    logic pend_ff, nxt_pend, cpend_ff, nxt_cpend, cnew_ff, nxt_cnew, lock_ff, nxt_lock;
    logic busy_ff, nxt_busy, init_ff, nxt_init;
    logic [AW-1:0] addr_ff, nxt_addr, iidx_ff, nxt_iidx;
    logic [PW-1:0] page_ff, nxt_page;
    logic [PAGE_BYTES-1:0] pval_ff, nxt_pval;
    logic [TW-1:0] tmr_ff, nxt_tmr;
    logic [6:0] pidx_ff, nxt_pidx;
    logic mem_we, pb_we;
    logic [AW-1:0] mem_wa;
    logic [7:0] mem_wd, pb_wd;
    logic [5:0] pb_wa;
    logic [7:0] mem [MEM_BYTES];
    logic [7:0] pbuf [PAGE_BYTES];

    secl_sync #(.W(2)) u_sync (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .d_i({bus.scl, bus.sda}),
        .q_o({scl_s, sda_s})
    );

    assign rise = scl_s & ~scl_d_ff;
    assign fall = ~scl_s & scl_d_ff;
    assign start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    assign stop = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
    assign b = {sh_ff[6:0], sda_s};
    assign cfg_rd = {CFG_RESET[7:LOCK_POS+1], lock_ff, CFG_RESET[LOCK_POS-1:0]};
    assign txb = ids_ff ? (a10_ff ? cfg_rd : fid_byte(uidx_ff)) : mem_q_ff;

    always_comb begin
        nxt_st = st_ff; nxt_role = role_ff; nxt_bc = bc_ff; nxt_uidx = uidx_ff;
        nxt_sh = sh_ff; nxt_ahi = ahi_ff; nxt_oe = oe_ff; nxt_ackd = ackd_ff;
        nxt_rw = rw_ff; nxt_ids = ids_ff; nxt_space_sel = space_sel_ff; nxt_a10 = a10_ff;
        nxt_pend = pend_ff; nxt_cpend = cpend_ff; nxt_cnew = cnew_ff; nxt_lock = lock_ff;
        nxt_busy = busy_ff; nxt_init = init_ff; nxt_addr = addr_ff; nxt_iidx = iidx_ff;
        nxt_page = page_ff; nxt_pval = pval_ff; nxt_tmr = tmr_ff; nxt_pidx = pidx_ff;
        nxt_scl_d = scl_s; nxt_sda_d = sda_s;
        mem_we = 1'b0; mem_wa = iidx_ff; mem_wd = ERASED;
        pb_we = 1'b0; pb_wa = addr_ff[5:0]; pb_wd = b;
        if (init_ff) begin
            // Erase walk after reset; headers are refused until it ends
            mem_we = 1'b1;
            nxt_iidx = iidx_ff + 1'b1;
            if (iidx_ff == AW'(MEM_BYTES - 1)) nxt_init = 1'b0;
        end else if (busy_ff) begin
            if (pidx_ff < 7'(PAGE_BYTES)) begin
                mem_we = pval_ff[pidx_ff[5:0]];
                mem_wa = {page_ff, pidx_ff[5:0]};
                mem_wd = pbuf[pidx_ff[5:0]];
                nxt_pidx = pidx_ff + 1'b1;
            end
            nxt_tmr = tmr_ff + 1'b1;
            if (tmr_ff == TW'(TWR - 1)) begin
                nxt_busy = 1'b0;
                nxt_pval = '0;
            end
        end
        if (start) begin
            nxt_st = S_RX;
            nxt_role = B_HDR;
            nxt_bc = 4'h0;
            nxt_oe = 1'b0;
        end else if (stop) begin
            nxt_st = S_IDLE;
            nxt_oe = 1'b0;
            nxt_pend = 1'b0;
            nxt_cpend = 1'b0;
            if (!busy_ff && !lock_ff && (pend_ff || cpend_ff)) begin
                nxt_busy = 1'b1;
                nxt_tmr = '0;
                nxt_pidx = pend_ff ? 7'h00 : 7'(PAGE_BYTES);
                if (cpend_ff) nxt_lock = cnew_ff;
            end
        end else begin
            case (st_ff)
                S_RX: if (rise) begin
                    nxt_sh = b;
                    nxt_bc = bc_ff + 1'b1;
                    if (bc_ff == 4'h7) begin
                        nxt_st = S_ACK;
                        nxt_bc = 4'h0;
                        nxt_ackd = 1'b1;
                        case (role_ff)
                            B_HDR: begin
                                nxt_rw = b[0];
                                nxt_ids = b[7:1] == IDS_HDR;
                                nxt_role = B_AHI;
                                nxt_ackd = !busy_ff && !init_ff && (b[7:1] == ARR_HDR ||
                                    (b[7:1] == IDS_HDR && (!b[0] || space_sel_ff)));
                                if (b[7:1] == IDS_HDR && b[0] && !space_sel_ff) begin
                                    nxt_pend = 1'b0;
                                    nxt_cpend = 1'b0;
                                end
                            end
                            B_AHI: begin
                                nxt_ahi = b;
                                nxt_role = B_ALO;
                                if (ids_ff) begin
                                    nxt_space_sel = b[SPACE_POS];
                                    nxt_a10 = b[CFGSEL_POS];
                                end
                            end
                            B_ALO: begin
                                nxt_role = B_DATA;
                                if (ids_ff) nxt_uidx = b[3:0];
                                else begin
                                    nxt_addr = {ahi_ff[6:0], b};
                                    nxt_page = {ahi_ff[6:0], b[7:6]};
                                end
                            end
                            default: begin
                                if (!ids_ff) begin
                                    nxt_ackd = !lock_ff;
                                    if (!lock_ff) begin
                                        pb_we = 1'b1;
                                        nxt_pval[addr_ff[5:0]] = 1'b1;
                                        nxt_pend = 1'b1;
                                        nxt_addr = {addr_ff[AW-1:6], addr_ff[5:0] + 6'h01};
                                    end
                                end else if (!space_sel_ff) begin
                                    nxt_ackd = 1'b0;
                                    nxt_pend = 1'b0;
                                    nxt_cpend = 1'b0;
                                end else if (a10_ff) begin
                                    nxt_ackd = !lock_ff;
                                    if (!lock_ff) begin
                                        nxt_cpend = 1'b1;
                                        nxt_cnew = b[LOCK_POS];
                                    end
                                end else begin
                                    nxt_ackd = 1'b0;
                                end
                            end
                        endcase
                    end
                end
                S_ACK: if (fall) begin
                    if (bc_ff == 4'h0) begin
                        nxt_oe = ackd_ff;
                        nxt_bc = 4'h1;
                    end else begin
                        nxt_oe = 1'b0;
                        nxt_bc = 4'h0;
                        if (!ackd_ff) nxt_st = S_IDLE;
                        else if (rw_ff) begin
                            nxt_st = S_TX;
                            nxt_sh = txb;
                            nxt_oe = ~txb[7];
                            nxt_bc = 4'h1;
                        end else nxt_st = S_RX;
                    end
                end
                S_TX: if (fall) begin
                    if (bc_ff == 4'h8) begin
                        nxt_oe = 1'b0;
                        nxt_st = S_MACK;
                    end else begin
                        nxt_oe = ~sh_ff[6];
                        nxt_sh = {sh_ff[6:0], 1'b0};
                        nxt_bc = bc_ff + 1'b1;
                    end
                end
                S_MACK: if (rise) begin
                    nxt_ackd = ~sda_s;
                    if (!ids_ff) nxt_addr = addr_ff + 1'b1;
                    else if (!a10_ff) nxt_uidx = uidx_ff + 1'b1;
                end else if (fall) begin
                    if (ackd_ff) begin
                        nxt_st = S_TX;
                        nxt_sh = txb;
                        nxt_oe = ~txb[7];
                        nxt_bc = 4'h1;
                    end else nxt_st = S_IDLE;
                end
                S_IDLE: ;
                default: nxt_st = S_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            st_ff <= S_IDLE; role_ff <= B_HDR; bc_ff <= 4'h0; uidx_ff <= 4'h0;
            sh_ff <= 8'h00; ahi_ff <= 8'h00; oe_ff <= 1'b0; ackd_ff <= 1'b0;
            rw_ff <= 1'b0; ids_ff <= 1'b0; space_sel_ff <= 1'b0; a10_ff <= 1'b0;
            pend_ff <= 1'b0; cpend_ff <= 1'b0; cnew_ff <= 1'b0;
            lock_ff <= CFG_RESET[LOCK_POS];
            busy_ff <= 1'b0; init_ff <= 1'b1; addr_ff <= '0; iidx_ff <= '0;
            page_ff <= '0; pval_ff <= '0; tmr_ff <= '0; pidx_ff <= 7'h00;
            scl_d_ff <= 1'b1; sda_d_ff <= 1'b1;
        end else begin
            st_ff <= nxt_st; role_ff <= nxt_role; bc_ff <= nxt_bc; uidx_ff <= nxt_uidx;
            sh_ff <= nxt_sh; ahi_ff <= nxt_ahi; oe_ff <= nxt_oe; ackd_ff <= nxt_ackd;
            rw_ff <= nxt_rw; ids_ff <= nxt_ids; space_sel_ff <= nxt_space_sel; a10_ff <= nxt_a10;
            pend_ff <= nxt_pend; cpend_ff <= nxt_cpend; cnew_ff <= nxt_cnew; lock_ff <= nxt_lock;
            busy_ff <= nxt_busy; init_ff <= nxt_init; addr_ff <= nxt_addr; iidx_ff <= nxt_iidx;
            page_ff <= nxt_page; pval_ff <= nxt_pval; tmr_ff <= nxt_tmr; pidx_ff <= nxt_pidx;
            scl_d_ff <= nxt_scl_d; sda_d_ff <= nxt_sda_d;
        end
    end

    // Storage has no reset; the erase walk supplies the delivered contents
    always_ff @(posedge mclk_i) begin
        if (mem_we) mem[mem_wa] <= mem_wd;
        mem_q_ff <= mem[addr_ff];
    end

    always_ff @(posedge mclk_i) begin
        if (pb_we) pbuf[pb_wa] <= pb_wd;
    end

    assign bus.s_sda_o = 1'b0;
    assign bus.s_sda_oe = oe_ff;
    assign busy_o = busy_ff;
    assign lock_o = lock_ff;
endmodule // secl_dev

// ==== src/secl_host.sv ====
`timescale 1ns/10ps
module secl_host import secl_pkg::*; #(
    parameter int TWR = TWR_CYC
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    secl_if.master bus,
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire secl_op_e cmd_op_i,
    input wire logic [7:0] cmd_data_i,
    input wire logic cmd_ack_i,
    output logic done_o,
    output logic [7:0] rdata_o,
    output logic nack_o
);
    typedef enum logic [2:0] {H_IDLE, H_START, H_BYTE, H_STOP, H_WAIT} secl_hst_e;

    secl_hst_e hst_ff, nxt_hst;
    logic [1:0] q_ff, nxt_q, bno_ff, nxt_bno;
    logic [DW-1:0] div_ff, nxt_div;
    logic [3:0] bit_ff, nxt_bit;
    logic [8:0] tx_ff, nxt_tx;
    logic [7:0] rx_ff, nxt_rx, rdata_ff, nxt_rdata;
    logic scl_ff, nxt_scl, oe_ff, nxt_oe, nack_ff, nxt_nack, done_ff, nxt_done;
    logic idw_ff, nxt_idw, cfgw_ff, nxt_cfgw, sda_s, tick;
    logic [TW-1:0] wt_ff, nxt_wt;

    secl_sync #(.W(1)) u_sync (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .d_i(bus.sda),
        .q_o(sda_s)
    );

    // The serial clock is made here from quarter-period enable pulses
    assign tick = div_ff == DW'(QTR_CYC - 1);

    always_comb begin
        nxt_hst = hst_ff; nxt_q = q_ff; nxt_bno = bno_ff; nxt_bit = bit_ff;
        nxt_tx = tx_ff; nxt_rx = rx_ff; nxt_rdata = rdata_ff; nxt_scl = scl_ff;
        nxt_oe = oe_ff; nxt_nack = nack_ff; nxt_done = 1'b0; nxt_idw = idw_ff;
        nxt_cfgw = cfgw_ff; nxt_wt = wt_ff;
        nxt_div = (hst_ff == H_IDLE || tick) ? '0 : div_ff + 1'b1;
        case (hst_ff)
            H_IDLE: if (cmd_valid_i) begin
                nxt_q = 2'h0;
                nxt_bit = 4'h0;
                case (cmd_op_i)
                    OP_START: nxt_hst = H_START;
                    OP_STOP: nxt_hst = H_STOP;
                    OP_WRITE: begin
                        nxt_hst = H_BYTE;
                        nxt_tx = {cmd_data_i, 1'b1};
                    end
                    default: begin
                        nxt_hst = H_BYTE;
                        nxt_tx = {8'hff, ~cmd_ack_i};
                    end
                endcase
            end
            H_START: if (tick) begin
                nxt_q = q_ff + 1'b1;
                case (q_ff)
                    2'h0: nxt_scl = 1'b0;
                    2'h1: nxt_oe = 1'b0;
                    2'h2: nxt_scl = 1'b1;
                    default: begin
                        nxt_oe = 1'b1;
                        nxt_hst = H_IDLE;
                        nxt_done = 1'b1;
                        nxt_bno = 2'h0;
                        nxt_idw = 1'b0;
                        nxt_cfgw = 1'b0;
                    end
                endcase
            end
            H_STOP: if (tick) begin
                nxt_q = q_ff + 1'b1;
                case (q_ff)
                    2'h0: nxt_scl = 1'b0;
                    2'h1: nxt_oe = 1'b1;
                    2'h2: nxt_scl = 1'b1;
                    default: begin
                        nxt_oe = 1'b0;
                        nxt_done = 1'b1;
                        nxt_wt = '0;
                        // Polling does not work after a config write, so hold off
                        nxt_hst = cfgw_ff ? H_WAIT : H_IDLE;
                    end
                endcase
            end
            H_BYTE: if (tick) begin
                nxt_q = q_ff + 1'b1;
                case (q_ff)
                    2'h0: nxt_scl = 1'b0;
                    2'h1: begin
                        nxt_oe = ~tx_ff[8];
                        nxt_tx = {tx_ff[7:0], 1'b1};
                    end
                    2'h2: nxt_scl = 1'b1;
                    default: begin
                        nxt_rx = {rx_ff[6:0], sda_s};
                        nxt_bit = bit_ff + 1'b1;
                        if (bit_ff == 4'h8) begin
                            nxt_hst = H_IDLE;
                            nxt_done = 1'b1;
                            nxt_rdata = rx_ff;
                            nxt_nack = sda_s;
                            if (bno_ff != 2'h3) nxt_bno = bno_ff + 1'b1;
                            if (bno_ff == 2'h0) nxt_idw = rx_ff == {IDS_HDR, 1'b0};
                            if (bno_ff == 2'h3 && idw_ff && !sda_s) nxt_cfgw = 1'b1;
                        end
                    end
                endcase
            end
            H_WAIT: begin
                nxt_wt = wt_ff + 1'b1;
                if (wt_ff == TW'(TWR - 1)) nxt_hst = H_IDLE;
            end
            default: nxt_hst = H_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            hst_ff <= H_IDLE; q_ff <= 2'h0; bno_ff <= 2'h0; div_ff <= '0;
            bit_ff <= 4'h0; tx_ff <= 9'h1ff; rx_ff <= 8'h00; rdata_ff <= 8'h00;
            scl_ff <= 1'b1; oe_ff <= 1'b0; nack_ff <= 1'b0; done_ff <= 1'b0;
            idw_ff <= 1'b0; cfgw_ff <= 1'b0; wt_ff <= '0;
        end else begin
            hst_ff <= nxt_hst; q_ff <= nxt_q; bno_ff <= nxt_bno; div_ff <= nxt_div;
            bit_ff <= nxt_bit; tx_ff <= nxt_tx; rx_ff <= nxt_rx; rdata_ff <= nxt_rdata;
            scl_ff <= nxt_scl; oe_ff <= nxt_oe; nack_ff <= nxt_nack; done_ff <= nxt_done;
            idw_ff <= nxt_idw; cfgw_ff <= nxt_cfgw; wt_ff <= nxt_wt;
        end
    end

    assign cmd_ready_o = hst_ff == H_IDLE;
    assign done_o = done_ff;
    assign rdata_o = rdata_ff;
    assign nack_o = nack_ff;
    assign bus.scl = scl_ff;
    assign bus.m_sda_o = 1'b0;
    assign bus.m_sda_oe = oe_ff;
endmodule // secl_host

// ==== test/secl_asserts.sv ====
`timescale 1ns/10ps
module secl_asserts #(parameter int TWR = 2000) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic scl,
    input wire logic sda,
    input wire logic s_sda_oe,
    input wire logic busy_o,
    input wire logic lock_o
);
    logic [19:0] busy_cnt_ff;
    logic [19:0] nxt_busy_cnt;
    logic [15:0] up_cnt_ff;
    logic [15:0] nxt_up_cnt;
    // Saturates so the erase window check goes quiet afterwards
    always_comb begin
        nxt_busy_cnt = busy_o ? busy_cnt_ff + 20'h1 : 20'h0;
        nxt_up_cnt = (&up_cnt_ff) ? up_cnt_ff : up_cnt_ff + 16'h1;
    end
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            busy_cnt_ff <= 20'h0;
            up_cnt_ff <= 16'h0;
        end else begin
            busy_cnt_ff <= nxt_busy_cnt;
            up_cnt_ff <= nxt_up_cnt;
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    sequence bus_idle;
        scl && sda;
    endsequence
    sequence drive_held;
        s_sda_oe [*8];
    endsequence
    a_busy_quiet: assert property (busy_o |-> !s_sda_oe) else $error("drive while busy");
    a_busy_length: assert property ($fell(busy_o) |-> int'(busy_cnt_ff) >= TWR - 1 &&
        int'(busy_cnt_ff) <= TWR + 1) else $error("busy length wrong");
    a_busy_after_stop: assert property ($rose(busy_o) |-> bus_idle) else $error("busy without stop");
    a_lock_sticky: assert property (!$fell(lock_o)) else $error("lock cleared");
    a_lock_no_write: assert property ($rose(busy_o) |-> !$past(lock_o)) else $error("program while locked");
    a_drive_scl_low: assert property ($changed(s_sda_oe) |-> !scl && !$past(scl)) else $error("drive edge");
    a_drive_min_len: assert property ($rose(s_sda_oe) |-> drive_held) else $error("drive too short");
    a_erase_quiet: assert property (!up_cnt_ff[15] |-> !s_sda_oe) else $error("drive during erase");
endmodule // secl_asserts

// ==== test/secl_tb.sv ====
`timescale 1ns/10ps
module secl_tb import secl_pkg::*; ;
    localparam int TWR_T = 2000;
    localparam logic [127:0] FACTORY_ID_T = 128'h0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2_e1f0; // Arbitrary value
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic cmd_valid_i = 1'b0;
    secl_op_e cmd_op_i = OP_START;
    logic [7:0] cmd_data_i = 8'h00;
    logic cmd_ack_i = 1'b0;
    logic cmd_ready_o;
    logic done_o;
    logic nack_o;
    logic busy_o;
    logic lock_o;
    logic [7:0] rdata_o;
    int bad_count = 0;
    int tests_run = 0;
    secl_if secl_if_i();
    secl_dev #(.TWR(TWR_T), .FACTORY_ID(FACTORY_ID_T)) secl_dev_i (.mclk_i(mclk_i), .nrst_i(nrst_i),
        .bus(secl_if_i.slave),
        .busy_o(busy_o), .lock_o(lock_o));
    secl_host #(.TWR(TWR_T)) secl_host_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .bus(secl_if_i.master),
        .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_op_i(cmd_op_i), .cmd_data_i(cmd_data_i),
        .cmd_ack_i(cmd_ack_i), .done_o(done_o), .rdata_o(rdata_o), .nack_o(nack_o));
    secl_asserts #(.TWR(TWR_T)) secl_asserts_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .scl(secl_if_i.scl),
        .sda(secl_if_i.sda), .s_sda_oe(secl_if_i.s_sda_oe), .busy_o(busy_o), .lock_o(lock_o));
    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded wait at falling edges; running out ends the run
    task automatic hold(input bit hi, ref logic s);
        int n = 0;
        while (s !== hi && n < 5000) begin
            @(negedge mclk_i);
            n++;
        end
        if (n == 5000) begin
            chk(8'h00, 8'h01);
            finish_test();
        end
    endtask
    task automatic op(input secl_op_e o, input logic [7:0] d, input logic a);
        hold(1'b1, cmd_ready_o);
        cmd_op_i = o;
        cmd_data_i = d;
        cmd_ack_i = a;
        cmd_valid_i = 1'b1;
        @(negedge mclk_i);
        cmd_valid_i = 1'b0;
        hold(1'b1, done_o);
    endtask
    task automatic wr(input logic [7:0] b, input logic nk);
        op(OP_WRITE, b, 1'b0);
        chk({7'h00, nack_o}, {7'h00, nk});
    endtask
    task automatic rd(input logic a, input logic [7:0] exp);
        op(OP_READ, 8'h00, a);
        chk(rdata_o, exp);
    endtask
    task automatic sel(input logic [7:0] h, input logic [15:0] ad);
        op(OP_START, 8'h00, 1'b0);
        wr(h, 1'b0);
        wr(ad[15:8], 1'b0);
        wr(ad[7:0], 1'b0);
    endtask
    task automatic rsel(input logic [7:0] h, input logic [15:0] ad, input logic nk);
        sel(h, ad);
        op(OP_START, 8'h00, 1'b0);
        wr(h | 8'h01, nk);
    endtask
    task automatic stp();
        op(OP_STOP, 8'h00, 1'b0);
    endtask
    // Busy rises only a few cycles after the STOP, so wait on the bus answer instead of the flag
    task automatic poll();
        int n = 0;
        do begin
            op(OP_START, 8'h00, 1'b0);
            op(OP_WRITE, 8'ha2, 1'b0);
            stp();
            n++;
        end while (nack_o !== 1'b0 && n < 32);
        chk({7'h00, nack_o}, 8'h00);
    endtask
    initial begin
        repeat (3) @(negedge mclk_i);
        nrst_i = 1'b1;
        repeat (32800) @(negedge mclk_i);
        rsel(8'ha2, 16'h1234, 1'b0);
        rd(1'b0, ERASED);
        stp();
        sel(8'ha2, 16'h1234);
        wr(8'ha5, 1'b0);
        stp();
        op(OP_START, 8'h00, 1'b0);
        wr(8'ha2, 1'b1);
        stp();
        poll();
        // Three bytes from offset 62: the third lands on offset 0 of the same page
        sel(8'ha2, 16'h003e);
        for (int i = 1; i <= 3; i++) wr(8'h11 * i, 1'b0);
        stp();
        poll();
        rsel(8'ha2, 16'h7fff, 1'b0);
        rd(1'b1, ERASED);
        rd(1'b1, 8'h33);
        rd(1'b0, ERASED);
        stp();
        rsel(8'ha2, 16'h003e, 1'b0);
        rd(1'b1, 8'h11);
        rd(1'b1, 8'h22);
        rd(1'b0, ERASED);
        stp();
        rsel(8'hb2, 16'h0600, 1'b0);
        rd(1'b1, CFG_RESET);
        rd(1'b0, CFG_RESET);
        stp();
        rsel(8'hb2, 16'h0200, 1'b0);
        for (int i = 0; i < 17; i++) rd(i < 16, FACTORY_ID_T[127 - 8 * (i % 16) -: 8]);
        stp();
        rsel(8'hb2, 16'h0000, 1'b1);
        stp();
        sel(8'hb2, 16'h0000);
        wr(8'h00, 1'b1);
        stp();
        sel(8'hb2, 16'h0600);
        wr(8'h02, 1'b0);
        stp();
        rsel(8'hb2, 16'h0600, 1'b0);
        chk({7'h00, lock_o}, 8'h01);
        rd(1'b0, CFG_RESET | (8'h01 << LOCK_POS));
        stp();
        sel(8'ha2, 16'h1234);
        wr(8'h5a, 1'b1);
        stp();
        sel(8'hb2, 16'h0600);
        wr(8'h00, 1'b1);
        stp();
        rsel(8'ha2, 16'h1234, 1'b0);
        rd(1'b0, 8'ha5);
        stp();
        finish_test();
    end
endmodule // secl_tb
